// ==== pkg/cen_pkg.sv ====
// Shared constants, event map and state types of the camera event notifier
package cen_pkg;
    // Sizes
    localparam int NUM_EV = 61;
    localparam int NUM_CH = 2;
    // Event source indices
    localparam int EV_ACQ = 0;
    localparam int EV_ACQ_ERR = 6;
    localparam int EV_FRAME = 7;
    localparam int EV_FRAME_TRIG = 9;
    localparam int EV_LINE = 15;
    localparam int EV_EXPO = 19;
    localparam int EV_STREAM = 21;
    localparam int EV_SEQ = 32;
    localparam int EV_CNT_START = 33;
    localparam int EV_CNT_END = 35;
    localparam int EV_TMR_START = 37;
    localparam int EV_TMR_END = 39;
    localparam int EV_ENC_STOP = 41;
    localparam int EV_ENC_RESTART = 43;
    localparam int EV_IO_RISE = 45;
    localparam int EV_IO_FALL = 47;
    localparam int EV_IO_ANY = 49;
    localparam int EV_LT_RISE = 51;
    localparam int EV_LT_FALL = 53;
    localparam int EV_LT_ANY = 55;
    localparam int EV_LINK_RATE = 57;
    localparam int EV_LATE = 58;
    localparam int EV_TEST = 59;
    localparam int EV_ERROR = 60;
    // Register byte offsets
    localparam logic [7:0] REG_SRC_SEL = 8'h00;
    localparam logic [7:0] REG_NOTIFY = 8'h04;
    localparam logic [7:0] REG_TEST = 8'h08;
    localparam logic [7:0] REG_IDLE = 8'h0C;
    localparam logic [7:0] REG_FT_TYPE = 8'h10;
    localparam logic [7:0] REG_FT_TIME = 8'h14;
    localparam logic [7:0] REG_FT_FRAME = 8'h18;
    localparam logic [7:0] REG_TIME = 8'h1C;
    localparam logic [7:0] REG_LINE_INV = 8'h20;
    // Notification settings
    localparam logic [1:0] NOTIFY_OFF = 2'h0;
    localparam logic [1:0] NOTIFY_ON = 2'h1;
    localparam logic [1:0] NOTIFY_ONCE = 2'h2;
    // Reset values
    localparam logic [5:0] RST_SEL = 6'h00;
    localparam logic [23:0] RST_IDLE = 24'h00FFFF;
    localparam logic [1:0] RST_INV = 2'h0;
    // Type identifier base, value is arbitrary
    localparam logic [15:0] TYPE_BASE = 16'h4000;
    // Edge detector state
    typedef struct packed {
        logic [NUM_CH-1:0] s1;
        logic [NUM_CH-1:0] s2;
        logic [NUM_CH-1:0] lvl;
        logic [NUM_CH-1:0] rise;
        logic [NUM_CH-1:0] fall;
    } cen_edge_t;
    // Encoder watchdog state
    typedef struct packed {
        logic [NUM_CH-1:0][23:0] cnt;
        logic [NUM_CH-1:0] stopped;
        logic [NUM_CH-1:0] stop_p;
        logic [NUM_CH-1:0] restart_p;
    } cen_enc_t;
    // One notification to the host
    typedef struct packed {
        logic valid;
        logic [15:0] type_id;
        logic [31:0] stamp;
        logic [31:0] frame;
    } cen_note_t;
    // Notifier state
    typedef struct packed {
        logic [5:0] sel;
        logic [NUM_EV-1:0][1:0] setting;
        logic [NUM_EV-1:0] pend;
        logic [NUM_EV-1:0][31:0] ev_time;
        logic [NUM_EV-1:0][31:0] ev_frame;
        logic [31:0] now;
        logic [23:0] idle_limit;
        logic [NUM_CH-1:0] line_inv;
        logic test_cmd;
        logic ack;
        logic [31:0] rdata;
        cen_note_t note;
        logic [31:0] ft_time;
        logic [31:0] ft_frame;
        logic [NUM_CH-1:0] cnt_prev;
        logic [NUM_CH-1:0] tmr_prev;
        logic [1:0] rate_prev;
        logic [3:0] seq_prev;
    } cen_state_t;
endpackage

// ==== hdl/cen_edge_det.sv ====
// Pin synchroniser with optional inversion and edge pulses
`timescale 1ns/1ns
module cen_edge_det import cen_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Pins and inversion
    input wire logic [NUM_CH-1:0] pin,
    input wire logic [NUM_CH-1:0] invert,
    // Level after inverter and edge pulses
    output logic [NUM_CH-1:0] level,
    output logic [NUM_CH-1:0] rise,
    output logic [NUM_CH-1:0] fall
);
    cen_edge_t st; // Registered state
    cen_edge_t nx; // Next state

    // Edges are judged after the inverter, so an inversion change shows as an edge
    always_comb begin
        nx = st;
        nx.s1 = pin;
        nx.s2 = st.s1;
        nx.lvl = st.s2 ^ invert;
        nx.rise = nx.lvl & ~st.lvl;
        nx.fall = ~nx.lvl & st.lvl;
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    assign level = st.lvl;
    assign rise = st.rise;
    assign fall = st.fall;
endmodule // cen_edge_det

// ==== hdl/cen_enc_watch.sv ====
// Encoder idle watchdog giving stopped and restarted pulses
`timescale 1ns/1ns
module cen_enc_watch import cen_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Motion pulses and idle limit in cycles
    input wire logic [NUM_CH-1:0] motion,
    input wire logic [23:0] limit,
    // Event pulses
    output logic [NUM_CH-1:0] stopped_p,
    output logic [NUM_CH-1:0] restart_p
);
    cen_enc_t st; // Registered state
    cen_enc_t nx; // Next state

    // Count idle cycles; stop fires once the idle count reaches the limit
    always_comb begin
        nx = st;
        nx.stop_p = '0;
        nx.restart_p = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (motion[i]) begin
                nx.cnt[i] = 24'h000000;
                nx.stopped[i] = 1'b0;
                nx.restart_p[i] = st.stopped[i];
            end else if (!st.stopped[i]) begin
                // At or past the limit, so a limit lowered below the idle run stops at once
                if (st.cnt[i] >= limit) begin
                    nx.stopped[i] = 1'b1;
                    nx.stop_p[i] = 1'b1;
                end else begin
                    nx.cnt[i] = st.cnt[i] + 24'h000001;
                end
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    assign stopped_p = st.stop_p;
    assign restart_p = st.restart_p;
endmodule // cen_enc_watch

// ==== hdl/cen_notifier.sv ====
// Camera event notifier: event capture, notification control and register slave
//
// Summary of operation
// [RULE1] Off setting sends no notification
// [RULE2] On setting notifies every occurrence; here repeats of a source while it is still pending merge into one notification
// [RULE3] Once notifies first occurrence, then turns off
// [RULE4] Test command always raises notified test event
// [RULE5] Late scheduled action raises late event
// [RULE6] Encoder idle past limit raises stopped
// [RULE7] Encoder moving again raises restarted
// [RULE8] I/O lines give rise, fall, any events
// [RULE9] Link triggers give rise, fall, any events
// [RULE10] Counters raise start and end events
// [RULE11] Timers raise start and end events
// [RULE12] Link rate change raises an event
// [RULE13] Errors raise error and acquisition error
// [RULE14] Acquisition level events are raised
// [RULE15] Frame level events are raised
// [RULE16] Frame burst start and end raised
// [RULE17] Line capture events are raised
// [RULE18] Exposure start and end are raised
// [RULE19] Stream transfer events are raised
// [RULE20] Stream queue overflow raises an event
// [RULE21] Sequencer set change raises an event
// [RULE22] Frame trigger carries type, time, frame
// [RULE23] Line edges judged after the inverter
// [RULE24] One-cycle pulses, timestamp taken same cycle
`timescale 1ns/1ns
module cen_notifier import cen_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Pulse event sources and the acquisition-active level
    input wire logic [5:0] ev_acq,
    input wire logic [7:0] ev_frame,
    input wire logic [3:0] ev_line,
    input wire logic [1:0] ev_expo,
    input wire logic [10:0] ev_stream,
    input wire logic error_p,
    input wire logic acq_active,
    // Level sources watched for change
    input wire logic [NUM_CH-1:0] cnt_run,
    input wire logic [NUM_CH-1:0] tmr_run,
    input wire logic [1:0] link_rate,
    input wire logic [3:0] seq_set,
    // Encoder motion pulses
    input wire logic [NUM_CH-1:0] enc_motion,
    // Scheduled action
    input wire logic action_valid,
    input wire logic [31:0] action_time,
    // Pins
    input wire logic [NUM_CH-1:0] line_pin,
    input wire logic [NUM_CH-1:0] link_trig,
    output logic [NUM_CH-1:0] line_level_sample,
    // Frame number in progress
    input wire logic [31:0] frame_num,
    // Host notification
    output cen_note_t notify,
    input wire logic notify_ready
);
    cen_state_t st; // Registered state
    cen_state_t nx; // Next state
    logic [NUM_EV-1:0] raw; // Event pulses this cycle
    logic [5:0] pick; // Lowest pending source
    logic hit; // Some source pending
    logic acc; // Bus access being answered
    logic wr_notify; // Software writes a setting
    logic [NUM_CH-1:0] io_rise; // Line edges
    logic [NUM_CH-1:0] io_fall;
    logic [NUM_CH-1:0] lt_rise; // Link trigger edges
    logic [NUM_CH-1:0] lt_fall;
    logic [NUM_CH-1:0] enc_stop; // Encoder events
    logic [NUM_CH-1:0] enc_restart;

    // I/O lines, inverted before edge detection
    cen_edge_det u_io (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .pin(line_pin),
        .invert(st.line_inv),
        .level(line_level_sample),
        .rise(io_rise),
        .fall(io_fall)
    );

    // Link triggers, never inverted
    cen_edge_det u_lt (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .pin(link_trig),
        .invert(RST_INV),
        .level(),
        .rise(lt_rise),
        .fall(lt_fall)
    );

    // Encoder watchdogs
    cen_enc_watch u_enc (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .motion(enc_motion),
        .limit(st.idle_limit),
        .stopped_p(enc_stop),
        .restart_p(enc_restart)
    );

    // Next-state logic: notify, then capture events, then bus
    always_comb begin
        nx = st;
        raw = '0;
        pick = 6'h00;
        hit = 1'b0;
        // Time base counts every cycle; stamps are raw cycle counts
        nx.now = st.now + 32'h00000001;
        nx.test_cmd = 1'b0;
        nx.rdata = 32'h00000000;
        // Ack high blocks a second take while the master still holds its strobe
        acc = wb_cyc_i & wb_stb_i & ~st.ack;
        nx.ack = acc;
        wr_notify = acc & wb_we_i & wb_sel_i[0] & (wb_adr_i == REG_NOTIFY);
        // Level trackers for change detection
        nx.cnt_prev = cnt_run;
        nx.tmr_prev = tmr_run;
        nx.rate_prev = link_rate;
        nx.seq_prev = seq_set;

        // Gather source pulses into one vector
        raw[EV_ACQ +: 6] = ev_acq; // [RULE14]
        raw[EV_ACQ_ERR] = error_p & acq_active; // [RULE13]
        raw[EV_ERROR] = error_p; // [RULE13]
        raw[EV_FRAME +: 8] = ev_frame; // [RULE15] [RULE16]
        raw[EV_LINE +: 4] = ev_line; // [RULE17]
        raw[EV_EXPO +: 2] = ev_expo; // [RULE18]
        raw[EV_STREAM +: 11] = ev_stream; // [RULE19] [RULE20]
        raw[EV_SEQ] = seq_set != st.seq_prev; // [RULE21]
        raw[EV_LINK_RATE] = link_rate != st.rate_prev; // [RULE12]
        raw[EV_CNT_START +: 2] = cnt_run & ~st.cnt_prev; // [RULE10]
        raw[EV_CNT_END +: 2] = ~cnt_run & st.cnt_prev; // [RULE10]
        raw[EV_TMR_START +: 2] = tmr_run & ~st.tmr_prev; // [RULE11]
        raw[EV_TMR_END +: 2] = ~tmr_run & st.tmr_prev; // [RULE11]
        raw[EV_ENC_STOP +: 2] = enc_stop; // [RULE6]
        raw[EV_ENC_RESTART +: 2] = enc_restart; // [RULE7]
        raw[EV_IO_RISE +: 2] = io_rise; // [RULE8] [RULE23]
        raw[EV_IO_FALL +: 2] = io_fall; // [RULE8]
        raw[EV_IO_ANY +: 2] = io_rise | io_fall; // [RULE8]
        raw[EV_LT_RISE +: 2] = lt_rise; // [RULE9]
        raw[EV_LT_FALL +: 2] = lt_fall; // [RULE9]
        raw[EV_LT_ANY +: 2] = lt_rise | lt_fall; // [RULE9]
        // Unsigned compare; the time base wraps after about 170 s
        raw[EV_LATE] = action_valid & (action_time < st.now); // [RULE5]
        raw[EV_TEST] = st.test_cmd; // [RULE4]

        // Retire the shown notification on handshake
        if (st.note.valid && notify_ready) begin
            nx.note.valid = 1'b0;
        end

        // Lowest index wins; one notification per two cycles at most
        for (int i = NUM_EV - 1; i >= 0; i--) begin
            if (st.pend[i]) begin
                pick = 6'(i);
                hit = 1'b1;
            end
        end
        if (!st.note.valid && hit) begin
            nx.note.valid = 1'b1;
            nx.note.type_id = TYPE_BASE + {10'h000, pick}; // [RULE22]
            nx.note.stamp = st.ev_time[pick];
            nx.note.frame = st.ev_frame[pick];
            nx.pend[pick] = 1'b0;
            // Keep the last notified frame trigger for software
            if (pick == 6'(EV_FRAME_TRIG)) begin
                nx.ft_time = st.ev_time[pick]; // [RULE22]
                nx.ft_frame = st.ev_frame[pick]; // [RULE22]
            end
        end

        // Capture after the clear, so a new occurrence wins over retiring
        // Test ignores its setting so the host can always probe the path
        for (int i = 0; i < NUM_EV; i++) begin
            if (raw[i] && (st.setting[i] != NOTIFY_OFF || i == EV_TEST)) begin // [RULE1] [RULE4]
                nx.pend[i] = 1'b1; // [RULE2]
                nx.ev_time[i] = st.now; // [RULE24]
                nx.ev_frame[i] = frame_num;
                if (st.setting[i] == NOTIFY_ONCE) begin
                    nx.setting[i] = NOTIFY_OFF; // [RULE3]
                end
            end
        end

        // Register writes; software setting wins over the once turn-off
        if (acc && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == REG_SRC_SEL) begin
                nx.sel = wb_dat_i[5:0];
            end else if (wb_adr_i == REG_NOTIFY) begin
                // Unused code 3 is stored as off
                if (st.sel < 6'(NUM_EV)) begin
                    nx.setting[st.sel] = (wb_dat_i[1:0] == 2'h3) ? NOTIFY_OFF : wb_dat_i[1:0];
                end
            end else if (wb_adr_i == REG_TEST) begin
                nx.test_cmd = wb_dat_i[0]; // [RULE4]
            end else if (wb_adr_i == REG_LINE_INV) begin
                nx.line_inv = wb_dat_i[1:0]; // [RULE23]
            end
        end
        // Idle limit honours byte lanes
        if (acc && wb_we_i && wb_adr_i == REG_IDLE) begin
            for (int b = 0; b < 3; b++) begin
                if (wb_sel_i[b]) begin
                    nx.idle_limit[8*b +: 8] = wb_dat_i[8*b +: 8];
                end
            end
        end

        // Register reads; unmapped offsets answer zero
        if (acc && !wb_we_i) begin
            if (wb_adr_i == REG_SRC_SEL) begin
                nx.rdata = {26'h0000000, st.sel};
            end else if (wb_adr_i == REG_NOTIFY) begin
                if (st.sel < 6'(NUM_EV)) begin
                    nx.rdata = {30'h00000000, st.setting[st.sel]};
                end
            end else if (wb_adr_i == REG_IDLE) begin
                nx.rdata = {8'h00, st.idle_limit};
            end else if (wb_adr_i == REG_FT_TYPE) begin
                nx.rdata = {16'h0000, TYPE_BASE + 16'(EV_FRAME_TRIG)}; // [RULE22]
            end else if (wb_adr_i == REG_FT_TIME) begin
                nx.rdata = st.ft_time; // [RULE22]
            end else if (wb_adr_i == REG_FT_FRAME) begin
                nx.rdata = st.ft_frame; // [RULE22]
            end else if (wb_adr_i == REG_TIME) begin
                nx.rdata = st.now;
            end else if (wb_adr_i == REG_LINE_INV) begin
                nx.rdata = {30'h00000000, st.line_inv};
            end
        end
    end

    // State register; all settings off after reset
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            st <= '0;
            st.sel <= RST_SEL;
            st.idle_limit <= RST_IDLE;
            st.line_inv <= RST_INV;
        end else begin
            st <= nx;
        end
    end

    // Outputs straight from the state register
    assign wb_dat_o = st.rdata;
    assign wb_ack_o = st.ack;
    assign notify = st.note;

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    off_no_send_a: assert property ( // [RULE1]
        raw[EV_FRAME_TRIG] && st.setting[EV_FRAME_TRIG] == NOTIFY_OFF && !st.pend[EV_FRAME_TRIG]
        |=> !st.pend[EV_FRAME_TRIG]) else $error("event queued while off");
    on_every_a: assert property ( // [RULE2]
        raw[EV_FRAME_TRIG] && st.setting[EV_FRAME_TRIG] == NOTIFY_ON
        |=> st.pend[EV_FRAME_TRIG] && st.setting[EV_FRAME_TRIG] == NOTIFY_ON) else $error("on event lost");
    once_turns_off_a: assert property ( // [RULE3]
        raw[EV_FRAME_TRIG] && st.setting[EV_FRAME_TRIG] == NOTIFY_ONCE && !wr_notify
        |=> st.pend[EV_FRAME_TRIG] && st.setting[EV_FRAME_TRIG] == NOTIFY_OFF) else $error("once not cleared");
    test_always_a: assert property ( // [RULE4]
        acc && wb_we_i && wb_sel_i[0] && wb_adr_i == REG_TEST && wb_dat_i[0]
        |=> ##1 st.pend[EV_TEST]) else $error("test event missing");
    late_action_a: assert property ( // [RULE5]
        action_valid && action_time < st.now && st.setting[EV_LATE] != NOTIFY_OFF
        |=> st.pend[EV_LATE]) else $error("late action missed");
    acq_error_a: assert property ( // [RULE13]
        error_p && acq_active && st.setting[EV_ACQ_ERR] != NOTIFY_OFF
        |=> st.pend[EV_ACQ_ERR]) else $error("acq error lost");
    count_edge_a: assert property ( // [RULE10]
        $rose(cnt_run[0]) |-> raw[EV_CNT_START] && !raw[EV_CNT_END]) else $error("counter start missed");
    rate_change_a: assert property ( // [RULE12]
        $changed(link_rate) |-> raw[EV_LINK_RATE]) else $error("rate change missed");
    stamp_same_a: assert property ( // [RULE24]
        raw[EV_FRAME_TRIG] && st.setting[EV_FRAME_TRIG] != NOTIFY_OFF
        |=> st.ev_time[EV_FRAME_TRIG] == $past(st.now)) else $error("timestamp not captured");
    ft_data_a: assert property ( // [RULE22]
        !st.note.valid && hit && pick == 6'(EV_FRAME_TRIG)
        |=> st.note.valid && st.ft_time == st.note.stamp && st.ft_frame == st.note.frame) else $error("frame data");
    ack_pulse_a: assert property (
        wb_ack_o |=> !wb_ack_o) else $error("ack held");
    // Bus data, host handshake and line edges hold their promises
    dat_zero_a: assert property (
        !wb_ack_o |-> wb_dat_o == 32'h00000000) else $error("read data outside ack");
    notify_hold_a: assert property ( // [RULE2]
        st.note.valid && !notify_ready |=> st.note.valid && $stable(st.note)) else $error("notification dropped");
    line_edge_a: assert property ( // [RULE23]
        io_rise[0] || io_fall[0] |-> $changed(line_level_sample[0])) else $error("edge without level change");

    notify_hs_c: cover property (st.note.valid && notify_ready);
    once_used_c: cover property (raw[EV_FRAME_TRIG] && st.setting[EV_FRAME_TRIG] == NOTIFY_ONCE);
    test_sent_c: cover property (st.note.valid && st.note.type_id == TYPE_BASE + 16'(EV_TEST));
    late_seen_c: cover property (raw[EV_LATE]);
    enc_stop_c: cover property (raw[EV_ENC_STOP]);
endmodule // cen_notifier

// ==== sim/cen_host_model.sv ====
// Host side model that takes notifications with random stalls
`timescale 1ns/1ns
module cen_host_model import cen_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Notification handshake
    input wire cen_note_t notify,
    output logic notify_ready,
    // Record of accepted notifications
    output int got,
    output cen_note_t last
);
    // Random readiness forces the device to hold its notification
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            notify_ready <= 1'b0;
            got <= 0;
            last <= '0;
        end else begin
            notify_ready <= 1'($urandom_range(0, 1));
            // Accept only when both sides agree at this edge
            if (notify.valid && notify_ready) begin
                got <= got + 1;
                last <= notify;
            end
        end
    end
endmodule // cen_host_model

// ==== sim/cen_notifier_tb.sv ====
// Self-checking bench of the camera event notifier
`timescale 1ns/1ns
module cen_notifier_tb import cen_pkg::*; ;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] dat_o;
    logic ack;
    logic [31:0] rdat;
    logic [60:0] pv = '0; // Pulse sources, bit number equals event index
    logic [13:0] lv = '0; // Counters, timers, rate, sequencer set, pins
    logic act = 1'b0;
    logic [1:0] mot = 2'h0;
    logic [31:0] at = 32'h0;
    logic [31:0] fnum = 32'h0;
    logic [1:0] lls;
    logic rdy;
    logic [31:0] s0;
    cen_note_t note;
    cen_note_t last;
    int got;
    int seen = 0;
    int cnt = 0;
    int pc = 0;
    int c0;
    int n_errors = 0;
    int compares = 0;
    // Level table: event index, level bit, new value
    int lt [14][3] = '{'{33, 0, 1}, '{35, 0, 0}, '{38, 3, 1}, '{40, 3, 0}, '{57, 4, 1}, '{32, 6, 1},
        '{45, 10, 1}, '{47, 10, 0}, '{49, 10, 1}, '{46, 11, 1}, '{51, 12, 1}, '{53, 12, 0},
        '{55, 12, 1}, '{56, 13, 1}};

    // Free running clock and a cycle count for stamp deltas
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cnt <= cnt + 1;

    cen_notifier cen_notifier_i (
        .sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .ev_acq(pv[5:0]), .ev_frame(pv[14:7]), .ev_line(pv[18:15]), .ev_expo(pv[20:19]),
        .ev_stream(pv[31:21]), .error_p(pv[60]), .acq_active(act), .cnt_run(lv[1:0]),
        .tmr_run(lv[3:2]), .link_rate(lv[5:4]), .seq_set(lv[9:6]), .enc_motion(mot),
        .action_valid(pv[58]), .action_time(at), .line_pin(lv[11:10]), .link_trig(lv[13:12]),
        .line_level_sample(lls), .frame_num(fnum), .notify(note), .notify_ready(rdy)
    );

    cen_host_model cen_host_model_i (
        .sys_clk(sys_clk), .reset_n(reset_n), .notify(note), .notify_ready(rdy),
        .got(got), .last(last)
    );

    // Verdict and end of run
    task automatic results();
        $display("Counts: %0d compares, %0d mismatches", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // A wait that ran out ends the run as a failure
    task automatic fail();
        n_errors++;
        $display("MISMATCH at %0t: wait ran out", $time);
        results();
    endtask

    // Single comparison point
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // Classic Wishbone cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge sys_clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        if (k >= 20)
            fail();
        rdat = dat_o;
        cyc <= 1'b0;
        we <= 1'b0;
    endtask

    // Select a source and give it a notification setting
    task automatic en(input int i, input logic [1:0] s);
        wb(1'b1, REG_SRC_SEL, 32'(i));
        wb(1'b1, REG_NOTIFY, {30'h0, s});
    endtask

    // One-cycle pulse on a source, with a fresh frame number
    task automatic pulse(input int i);
        @(posedge sys_clk);
        pc = cnt;
        fnum <= $urandom;
        pv <= 61'h1 << i;
        @(posedge sys_clk);
        pv <= '0;
    endtask

    // Wait for the next accepted notification and check its content
    task automatic expect_note(input int i);
        int k;
        k = 0;
        while (got <= seen && k < 80) begin
            @(posedge sys_clk);
            k++;
        end
        if (k >= 80)
            fail();
        seen++;
        chk(32'(last.type_id), TYPE_BASE + i);
        chk(last.frame, fnum);
    endtask

    // No notification may arrive in a quiet window
    task automatic none();
        repeat (16) @(posedge sys_clk);
        chk(got, seen);
    endtask

    initial begin
        void'($urandom(44917));
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        // Reset values, read-only type and an unmapped place
        wb(1'b0, REG_IDLE, 32'h0);
        chk(rdat, 32'h00FFFF);
        wb(1'b0, REG_NOTIFY, 32'h0);
        chk(rdat, 32'h0);
        wb(1'b1, REG_FT_TYPE, 32'h0);
        wb(1'b0, REG_FT_TYPE, 32'h0);
        chk(rdat, TYPE_BASE + EV_FRAME_TRIG);
        wb(1'b0, 8'h40, 32'h0);
        chk(rdat, 32'h0);
        $display("test reset done");
        pulse(EV_FRAME_TRIG);
        none();
        $display("test off done");
        // Pulse sources 0 to 31 twice, bar the acquisition error; stamp gap must match the cycle gap
        for (int i = 0; i < 32; i++) begin
            if (i != EV_ACQ_ERR) begin
                en(i, NOTIFY_ON);
                pulse(i);
                expect_note(i);
                s0 = last.stamp;
                c0 = pc;
                pulse(i);
                expect_note(i);
                chk(last.stamp - s0, 32'(pc - c0));
                en(i, NOTIFY_OFF);
            end
        end
        $display("test pulses done");
        // Once: first occurrence only, then the setting reads off
        en(EV_FRAME_TRIG, NOTIFY_ONCE);
        pulse(EV_FRAME_TRIG);
        expect_note(EV_FRAME_TRIG);
        wb(1'b0, REG_FT_FRAME, 32'h0);
        chk(rdat, fnum);
        // Time base is zero until the edge after reset, so the stamp is pc less two
        wb(1'b0, REG_FT_TIME, 32'h0);
        chk(rdat, 32'(pc - 2));
        pulse(EV_FRAME_TRIG);
        none();
        wb(1'b0, REG_NOTIFY, 32'h0);
        chk(rdat, 32'(NOTIFY_OFF));
        en(EV_FRAME_TRIG, 2'h3);
        wb(1'b0, REG_NOTIFY, 32'h0);
        chk(rdat, 32'(NOTIFY_OFF));
        $display("test once done");
        // Error during acquisition gives both error events, lowest first
        act <= 1'b1;
        en(EV_ACQ_ERR, NOTIFY_ON);
        en(EV_ERROR, NOTIFY_ON);
        pulse(EV_ERROR);
        expect_note(EV_ACQ_ERR);
        expect_note(EV_ERROR);
        en(EV_ERROR, NOTIFY_OFF);
        en(EV_ACQ_ERR, NOTIFY_OFF);
        $display("test error done");
        // Test command ignores the settings
        wb(1'b1, REG_TEST, 32'h1);
        expect_note(EV_TEST);
        $display("test command done");
        // Action in the past is late, one far ahead is not
        en(EV_LATE, NOTIFY_ON);
        pulse(EV_LATE);
        expect_note(EV_LATE);
        at <= 32'hFFFFFFFF;
        pulse(EV_LATE);
        none();
        en(EV_LATE, NOTIFY_OFF);
        $display("test late done");
        // Level changes and pin edges from the table
        for (int i = 0; i < 14; i++) begin
            en(lt[i][0], NOTIFY_ON);
            @(posedge sys_clk);
            fnum <= $urandom;
            lv[lt[i][1]] <= lt[i][2][0];
            expect_note(lt[i][0]);
            en(lt[i][0], NOTIFY_OFF);
        end
        $display("test levels done");
        // Inversion alone makes a falling edge after the inverter
        en(EV_IO_FALL, NOTIFY_ON);
        wb(1'b1, REG_LINE_INV, 32'h1);
        expect_note(EV_IO_FALL);
        chk(32'(lls), 32'h2);
        en(EV_IO_FALL, NOTIFY_OFF);
        wb(1'b1, REG_LINE_INV, 32'h0);
        $display("test inversion done");
        // Short idle limit stops encoder 0; motion restarts it
        en(EV_ENC_STOP, NOTIFY_ON);
        wb(1'b1, REG_IDLE, 32'h5);
        expect_note(EV_ENC_STOP);
        wb(1'b0, REG_IDLE, 32'h0);
        chk(rdat, 32'h5);
        en(EV_ENC_STOP, NOTIFY_OFF);
        en(EV_ENC_RESTART, NOTIFY_ON);
        @(posedge sys_clk);
        mot <= 2'h1;
        @(posedge sys_clk);
        mot <= 2'h0;
        expect_note(EV_ENC_RESTART);
        en(EV_ENC_RESTART, NOTIFY_OFF);
        none();
        $display("test encoder done");
        results();
    end
endmodule // cen_notifier_tb
